// ---- hdl/table_read_regs.vh ----
`ifndef TABLE_READ_REGS_VH
`define TABLE_READ_REGS_VH
// Data-memory addresses of the look-up table registers
`define ADDR_TABLE_PTR_LOW   8'h07
`define ADDR_TABLE_HIGH_DATA 8'h08
`define ADDR_TABLE_PTR_HIGH  8'h1F
// Program memory vectors
`define VEC_RESET            12'h000
`define VEC_TIMER0           12'h008
`define VEC_TIMER1           12'h00C
// Last page upper address bits
`define LAST_PAGE_HI         4'hF
// Reset values
`define RST_BYTE             8'h00
`define RST_ADDR             12'h000
// Table read length in instruction cycles
`define TBL_CYCLES           2'd2
`endif

// ---- hdl/table_addr_gen.v ----
`timescale 1ns/1ps
`default_nettype none
// Forms the 12-bit table address for both table read flavours
module table_addr_gen #(
    parameter HIGH_PTR_EN = 1
) (
    input  wire [11:0] pcNow,
    input  wire [7:0]  ptrLow,
    input  wire [7:0]  ptrHigh,
    input  wire        lastPage,
    output wire [11:0] tableAddr
);
`include "table_read_regs.vh"
    // Page bits: last page forced high, else pointer or current page
    wire [3:0] pageBits;
    assign pageBits = lastPage ? `LAST_PAGE_HI :
                      (HIGH_PTR_EN != 0) ? ptrHigh[3:0] :
                      pcNow[11:8];
    assign tableAddr = {pageBits, ptrLow};
endmodule
`default_nettype wire

// ---- hdl/program_memory_table_read.v ----
`timescale 1ns/1ps
`default_nettype none
module program_memory_table_read #(
    parameter HIGH_PTR_EN = 1,
    parameter WORD_W      = 15
) (
    input  wire              sys_clk,
    input  wire              reset,
    // Data-memory register port
    input  wire [7:0]        dmAddr,
    input  wire              dmWrEn,
    input  wire [7:0]        dmWrData,
    output reg  [7:0]        dmRdData,
    // Table read requests from instruction decode
    input  wire              readCurPage,
    input  wire              readLastPage,
    input  wire [7:0]        destAddr,
    input  wire [11:0]       pcNow,
    // Program memory read port
    output reg  [11:0]       pmAddr,
    input  wire [WORD_W-1:0] pmData,
    // Destination byte write toward RAM
    output reg               destWrEn,
    output reg  [7:0]        destAddrOut,
    output reg  [7:0]        destData,
    output wire              tblBusy,
    // Interrupt vectoring
    input  wire              timer0Ovf,
    input  wire              timer0IntEn,
    input  wire              timer1Ovf,
    input  wire              timer1IntEn,
    input  wire              stackFull,
    output reg               vectorTake,
    output reg  [11:0]       vectorAddr
);
`include "table_read_regs.vh"
    localparam ST_IDLE = 1'b0;
    localparam ST_READ = 1'b1;

    reg              state_r;       // Sequencer state
    reg  [7:0]       tblPtrLow_r;   // Low table pointer
    reg  [7:0]       tblPtrHigh_r;  // High table pointer
    reg  [7:0]       highData_r;    // Read-only high-data register
    reg  [7:0]       destHold_r;    // Destination captured at start
    wire [11:0]      tableAddr;     // Formed table address
    wire [7:0]       upperBits;     // Word bits above the low byte

    // Address former keeps the page selection in one place
    table_addr_gen #(
        .HIGH_PTR_EN (HIGH_PTR_EN)
    ) u_addr (
        .pcNow     (pcNow),
        .ptrLow    (tblPtrLow_r),
        .ptrHigh   (tblPtrHigh_r),
        .lastPage  (readLastPage),
        .tableAddr (tableAddr)
    );

    // Zero-fill the high byte above the word width
    assign upperBits = {{(16-WORD_W){1'b0}}, pmData[WORD_W-1:8]};
    assign tblBusy   = (state_r == ST_READ);

    // Table read sequencer: issue cycle then transfer cycle
    always @(posedge sys_clk) begin
        if (reset) begin
            state_r     <= ST_IDLE;
            pmAddr      <= `RST_ADDR;
            destHold_r  <= `RST_BYTE;
            destWrEn    <= 1'b0;
            destAddrOut <= `RST_BYTE;
            destData    <= `RST_BYTE;
            highData_r  <= `RST_BYTE;
        end else begin
            destWrEn <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    // Start a read; last page wins if both requested
                    if (readCurPage || readLastPage) begin
                        pmAddr     <= tableAddr;
                        destHold_r <= destAddr;
                        state_r    <= ST_READ;
                    end
                end
                ST_READ: begin
                    // Second cycle: move both bytes out together
                    destWrEn    <= 1'b1;
                    destAddrOut <= destHold_r;
                    destData    <= pmData[7:0];
                    highData_r  <= upperBits;
                    state_r     <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Pointer registers; high-data has no data-memory write path, only the sequencer loads it
    always @(posedge sys_clk) begin
        if (reset) begin
            tblPtrLow_r  <= `RST_BYTE;
            tblPtrHigh_r <= `RST_BYTE;
        end else if (dmWrEn) begin
            if (dmAddr == `ADDR_TABLE_PTR_LOW)
                tblPtrLow_r <= dmWrData;
            if (dmAddr == `ADDR_TABLE_PTR_HIGH)
                tblPtrHigh_r <= dmWrData;
        end
    end

    // Registered read data; unmapped addresses return zero
    always @(posedge sys_clk) begin
        if (reset) begin
            dmRdData <= `RST_BYTE;
        end else begin
            case (dmAddr)
                `ADDR_TABLE_PTR_LOW:   dmRdData <= tblPtrLow_r;
                `ADDR_TABLE_PTR_HIGH:  dmRdData <= tblPtrHigh_r;
                `ADDR_TABLE_HIGH_DATA: dmRdData <= highData_r;
                default:               dmRdData <= `RST_BYTE;
            endcase
        end
    end

    // Vectoring: timer0 has priority; a full stack holds the request off
    always @(posedge sys_clk) begin
        if (reset) begin
            vectorTake <= 1'b0;
            vectorAddr <= `VEC_RESET;
        end else begin
            vectorTake <= 1'b0;
            if (!stackFull && timer0Ovf && timer0IntEn) begin
                vectorTake <= 1'b1;
                vectorAddr <= `VEC_TIMER0;
            end else if (!stackFull && timer1Ovf && timer1IntEn) begin
                vectorTake <= 1'b1;
                vectorAddr <= `VEC_TIMER1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- test/prog_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Program store behind the reader; each word encodes its own address,
// so a wrong page or offset shows up in the data returned
module prog_mem_model (
    input  wire logic [11:0] pmAddr,
    output logic      [14:0] pmData
);
    assign pmData = {pmAddr[11:5], pmAddr[7:0] ^ 8'hA5};
endmodule
`default_nettype wire

// ---- test/tr_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// Watches the table reader and vector logic at the top ports
module tr_asserts #(parameter HIGH_PTR_EN = 1, parameter WORD_W = 15) (
    input wire logic sys_clk, reset, readCurPage, readLastPage, tblBusy, destWrEn, vectorTake, stackFull,
    input wire logic timer0Ovf, timer0IntEn, timer1Ovf, timer1IntEn,
    input wire logic [7:0] dmAddr, dmRdData, destAddr, destAddrOut, destData,
    input wire logic [11:0] pcNow, pmAddr, vectorAddr,
    input wire logic [WORD_W-1:0] pmData
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    wire q0 = timer0Ovf && timer0IntEn && !stackFull;
    wire q1 = timer1Ovf && timer1IntEn && !stackFull;
    // A start is only taken while the unit is idle
    wire go = (readCurPage || readLastPage) && !tblBusy;
    property p_v0; q0 |=> vectorTake && vectorAddr == 12'h008; endproperty
    a_v0: assert property (p_v0) else $error("timer0 vector wrong");
    property p_v1; q1 && !q0 |=> vectorTake && vectorAddr == 12'h00C; endproperty
    a_v1: assert property (p_v1) else $error("timer1 vector wrong");
    property p_sf; stackFull |=> !vectorTake; endproperty
    a_sf: assert property (p_sf) else $error("vector with full stack");
    property p_len; go |=> tblBusy ##1 (destWrEn && !tblBusy); endproperty
    a_len: assert property (p_len) else $error("table read length");
    property p_last; go && readLastPage |=> pmAddr[11:8] == 4'hF; endproperty
    a_last: assert property (p_last) else $error("last page bits");
    property p_page; go && !readLastPage && HIGH_PTR_EN == 0 |=> pmAddr[11:8] == $past(pcNow[11:8]); endproperty
    a_page: assert property (p_page) else $error("current page bits");
    property p_low; destWrEn |-> destData == $past(pmData[7:0]) && destAddrOut == $past(destAddr, 2); endproperty
    a_low: assert property (p_low) else $error("low byte transfer");
    property p_ro; dmAddr == 8'h08 ##1 (dmAddr == 8'h08 && !destWrEn) |=> $stable(dmRdData); endproperty
    a_ro: assert property (p_ro) else $error("high data changed");
    property p_b7; dmAddr == 8'h08 |=> !dmRdData[7]; endproperty
    a_b7: assert property (p_b7) else $error("high data bit7 set");
endmodule
bind program_memory_table_read tr_asserts #(.HIGH_PTR_EN(HIGH_PTR_EN), .WORD_W(WORD_W)) chk_u (.*);
`default_nettype wire

// ---- test/test_program_memory_table_read.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_program_memory_table_read;
    logic sys_clk = 0, reset = 1, dmWrEn = 0, readCurPage = 0, readLastPage = 0, stackFull = 0;
    logic timer0Ovf = 0, timer0IntEn = 0, timer1Ovf = 0, timer1IntEn = 0, destWrEn, tblBusy, vectorTake, q0, q1;
    logic [7:0] dmAddr = 0, dmWrData = 0, destAddr = 0, dmRdData, destAddrOut, destData, v, lo = 0, hi = 0, ph = 0;
    logic [11:0] pcNow = 0, pmAddr, vectorAddr, pa0, ea;
    logic [14:0] pmData;
    int fails = 0, n_checks = 0, cyc = 0;
    program_memory_table_read dut_u (.*);
    // Twin with the high pointer option off; only its program address is watched
    program_memory_table_read #(.HIGH_PTR_EN(0)) dut_p0 (.*, .pmAddr(pa0), .dmRdData(), .destWrEn(),
        .destAddrOut(), .destData(), .tblBusy(), .vectorTake(), .vectorAddr());
    prog_mem_model mem_u (.*);
    always #10 sys_clk = ~sys_clk;
    // Hang guard, far above the few hundred cycles needed
    always @(posedge sys_clk) if (++cyc > 3000) begin fails++; tally_and_finish; end
    task automatic chk(string nm, logic [15:0] e, s);
        n_checks++;
        if (e !== s) begin fails++; $display("[FAIL] %s expected %h seen %h", nm, e, s); end
    endtask
    task automatic wr(logic [7:0] a, d);
        @(posedge sys_clk) {dmAddr, dmWrData, dmWrEn} <= {a, d, 1'b1};
        @(posedge sys_clk) dmWrEn <= 0;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge sys_clk) dmAddr <= a;
        @(posedge sys_clk) #1 v = dmRdData;
    endtask
    // Request held into the busy cycle, where a second start must be refused
    task automatic tr(logic last);
        ea = last ? {4'hF, lo} : {hi[3:0], lo};
        @(posedge sys_clk) {readLastPage, readCurPage, destAddr, pcNow} <= {last, !last, hi, 12'($urandom)};
        repeat (2) @(posedge sys_clk);
        {readLastPage, readCurPage} <= 0;
        #1 chk("destWrEn", 1, destWrEn);
        chk("destByte", {hi, ea[7:0] ^ 8'hA5}, {destAddrOut, destData});
        chk("pmAddr", ea, pmAddr);
        chk("pmAddrOff", last ? ea : {pcNow[11:8], lo}, pa0);
        rd(8'h08);
        ph = {1'b0, ea[11:5]};
        chk("highData", ph, v);
        chk("refused", 0, destWrEn);
    endtask
    initial begin
        void'($urandom(32'h7bf8_8ebc));
        repeat (10) @(posedge sys_clk);
        reset <= 0;
        for (int i = 0; i < 20; i++) begin
            rd(8'h07);
            chk("ptrLow", lo, v);
            rd(8'h1F);
            chk("ptrHigh", hi, v);
            wr(8'h08, 8'($urandom));
            rd(8'h08);
            chk("highDataKept", ph, v);
            {lo, hi} = i < 4 ? {16{i[1]}} : 16'($urandom);
            wr(8'h07, lo);
            wr(8'h1F, hi);
            tr(i[0]);
        end
        for (int k = 0; k < 32; k++) begin
            @(posedge sys_clk) {stackFull, timer1IntEn, timer1Ovf, timer0IntEn, timer0Ovf} <= 5'(k);
            q0 = k[0] & k[1] & !k[4];
            q1 = k[2] & k[3] & !k[4];
            @(posedge sys_clk) #1 chk("vector", {q0 | q1, q0 ? 12'h008 : q1 ? 12'h00C : 12'h000},
                {vectorTake, vectorTake ? vectorAddr : 12'h000});
        end
        tally_and_finish;
    end
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
endmodule
`default_nettype wire
